// File: design/pms_pkg.sv
/*
  Constants shared by the power mode sequencer: register offsets, field positions,
  reset values and the sequencer state enumeration.
  Assumes a 32-bit peripheral register port addressed by byte offset.
*/
package pms_pkg;

  // Register byte offsets
  localparam logic [7:0] PMS_OFS_GENERAL = 8'h00;
  localparam logic [7:0] PMS_OFS_WAKE_LO = 8'h04;
  localparam logic [7:0] PMS_OFS_WAKE_HI = 8'h08;
  localparam logic [7:0] PMS_OFS_DORMANT = 8'h0C;
  localparam logic [7:0] PMS_OFS_RESUME1 = 8'h10;
  localparam logic [7:0] PMS_OFS_RESUME2 = 8'h14;
  localparam logic [7:0] PMS_OFS_ACTIVE = 8'h18;
  localparam logic [7:0] PMS_OFS_SUSPEND1 = 8'h1C;
  localparam logic [7:0] PMS_OFS_SUSPEND2 = 8'h20;
  localparam logic [7:0] PMS_OFS_SEQ_STATUS = 8'h24;
  localparam logic [7:0] PMS_OFS_REG_CTRL = 8'h2C;
  localparam logic [7:0] PMS_OFS_SUPPLY_STATUS = 8'h30;
  localparam logic [7:0] PMS_OFS_CORE_LEVEL = 8'h34;
  localparam logic [7:0] PMS_OFS_PLL_LEVEL = 8'h40;

  // General control field positions
  localparam int PMS_GC_USB_UP = 9;
  localparam int PMS_GC_USB_DOWN = 8;
  localparam int PMS_GC_DEFAULT_LEVELS = 7;
  localparam int PMS_GC_REAPPLY = 6;
  localparam int PMS_GC_WIDE_TIMER = 5;
  localparam int PMS_GC_TIMER_WAKE = 4;
  localparam int PMS_GC_PIN_POL = 3;
  localparam int PMS_GC_PIN_WAKE = 2;
  localparam int PMS_GC_SLEEP_GO = 1;
  localparam int PMS_GC_SLEEP_CLK = 0;
  localparam logic [31:0] PMS_GC_RESET = 32'h0000_0008;
  localparam logic [31:0] PMS_GC_RW_MASK = 32'h0000_03BF;

  // State register field positions
  localparam int PMS_ST_DWELL_LSB = 16;
  localparam int PMS_ST_CLK_STOP = 14;
  localparam int PMS_ST_ANA_PFM = 9;
  localparam int PMS_ST_CORE_PFM = 8;
  localparam int PMS_ST_IO_EN = 5;
  localparam int PMS_ST_PLL_EN = 4;
  localparam int PMS_ST_ANA_EN = 1;
  localparam int PMS_ST_CORE_EN = 0;
  localparam logic [31:0] PMS_ST_RW_MASK = 32'h001F_4331;
  localparam logic [31:0] PMS_ACTIVE_RW_MASK = 32'h0000_4331;

  // State register reset values
  localparam logic [31:0] PMS_DORMANT_RESET = 32'h0010_0000;
  localparam logic [31:0] PMS_RESUME1_RESET = 32'h0010_0020;
  localparam logic [31:0] PMS_RESUME2_RESET = 32'h0010_0033;
  localparam logic [31:0] PMS_ACTIVE_RESET = 32'h0000_0033;
  localparam logic [31:0] PMS_SUSPEND1_RESET = 32'h0010_0033;
  localparam logic [31:0] PMS_SUSPEND2_RESET = 32'h0010_0020;
  localparam logic [31:0] PMS_LEVEL_RESET = 32'h0000_0000;

  // Sequencer states
  typedef enum logic [2:0] {
    PMS_DORMANT,
    PMS_RESUME_PHASE_ONE,
    PMS_RESUME_PHASE_TWO,
    PMS_ACTIVE_STATE,
    PMS_SUSPEND_PHASE_ONE,
    PMS_SUSPEND_PHASE_TWO
  } pms_state_e;

endpackage : pms_pkg

// File: design/pms_power_mode_sequencer.sv
/*
  Power mode sequencer: register file, wake detection, dwell counting and the
  cyclic power state machine driving supply enables, modulation and tile clock gate.
  Assumes a word-wide register port with one-cycle read/write strobes, supply good
  inputs from the regulators, and a slow clock tick while the sleep clock is in use.
*/
`timescale 1ns/1ns

// Overview of operation
// - All registers are accessed only as whole 32-bit words.
// - General control bit 9 selects USB suspend power-up enable; resets to 0.
// - General control bit 8 selects USB suspend power-down enable; resets to 0.
// - Bit 7 chooses stored level registers (0) or power-on levels (1) at wake.
// - Writing bit 6 re-applies active state settings; bit self clears.
// - Bit 5 selects 64-bit wake comparison, else 32-bit; resets to 0.
// - Bit 4 enables timer wake; low wake word used only when asleep.
// - High wake word ignored unless 64-bit compare; both words reset to 0.
// - Bit 2 enables waking when the wake pin reaches its active level.
// - Bit 3 picks wake pin polarity: 1 high (reset), 0 low.
// - Writing 1 to bit 1 starts sleep sequence; bit self clears.
// - Bit 0 picks asleep clock: 1 default, 0 slow oscillator, asleep only.
// - Stay asleep for the minimum dwell, then leave only on a wake condition.
// - Asleep dwell counts on the enabled clock, possibly the slow oscillator.
// - Bits 20:16 of the non-active state registers hold log2 of dwell cycles, 1 to 2^31; reset 16.
// - State bit 14 stops the processor tile clock in that state.
// - State bits 9 and 8 pick analogue and core modulation: 0 PWM, 1 PFM.
// - State bits 5, 4, 0 enable IO, PLL and core supplies; asleep register resets them to 0.
// - State bit 1, analogue enable, is read-only and zero when asleep.
// - In resume states, advance after dwell only when enabled supplies are good.
module pms_power_mode_sequencer
  import pms_pkg::*;
#(
  parameter int DWELL_W = 32 // Width of the dwell counter
) (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic [7:0] reg_addr, // Register byte offset
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic reg_rd, // Read strobe, one cycle
  input wire logic [31:0] reg_wdata, // Write data
  output logic [31:0] reg_rdata, // Read data, valid the cycle after reg_rd
  input wire logic [63:0] rtc_count, // Real-time counter value
  input wire logic wake_pin, // External wake pin level
  input wire logic slow_tick, // One pulse per slow oscillator cycle
  input wire logic core_good, // Core regulator good
  input wire logic ana_good, // Analogue regulator good
  input wire logic pll_good, // PLL supply regulator good
  input wire logic io_good, // IO supply output good
  output logic core_regulator_en, // Core regulator enable
  output logic analogue_regulator_en, // Analogue regulator enable
  output logic pll_supply_regulator_en, // PLL supply regulator enable
  output logic io_supply_output_en, // IO supply output enable
  output logic core_regulator_pfm, // Core regulator PFM when high
  output logic analogue_regulator_pfm, // Analogue regulator PFM when high
  output logic tile_clk_stop, // Stops processor tile clock when high
  output logic sleep_clk_default, // Asleep clock is default clock when high
  output logic usb_pwr_up_en, // USB suspend power-up enable
  output logic usb_pwr_down_en, // USB suspend power-down enable
  output logic use_default_levels, // Apply power-on levels at wake
  output logic [31:0] core_level, // Stored core voltage rail level
  output logic [31:0] pll_level, // Stored PLL supply level
  output logic [2:0] seq_state // Current sequencer state
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [31:0] gen_reg;
  logic [31:0] wake_lo_reg;
  logic [31:0] wake_hi_reg;
  logic [31:0] state_reg [6];
  logic [31:0] reg_ctrl_reg;
  logic [31:0] core_level_reg;
  logic [31:0] pll_level_reg;
  logic [31:0] rdata_next;
  pms_state_e state_reg_q;
  pms_state_e state_next;
  logic [DWELL_W-1:0] dwell_reg;
  logic dwell_done;
  logic reapply_reg;
  logic wake_hit;
  logic supplies_good;
  logic [31:0] cur_cfg;
  logic count_tick;
  logic [4:0] cur_log2;

  // Writes to general control; sleep-go clears itself outside the active state, re-apply bit is masked off
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      gen_reg <= PMS_GC_RESET;
    end else begin
      if (reg_wr && reg_addr == PMS_OFS_GENERAL) begin
        gen_reg <= reg_wdata & PMS_GC_RW_MASK;
      end else if (state_reg_q != PMS_ACTIVE_STATE) begin
        gen_reg[PMS_GC_SLEEP_GO] <= 1'b0;
      end
    end
  end

  // Re-apply pulse, never stored in the readable register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reapply_reg <= 1'b0;
    end else begin
      reapply_reg <= reg_wr && reg_addr == PMS_OFS_GENERAL && reg_wdata[PMS_GC_REAPPLY];
    end
  end

  // Wake time words
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_lo_reg <= 32'h0000_0000;
      wake_hi_reg <= 32'h0000_0000;
    end else if (reg_wr) begin
      if (reg_addr == PMS_OFS_WAKE_LO) begin
        wake_lo_reg <= reg_wdata;
      end
      if (reg_addr == PMS_OFS_WAKE_HI) begin
        wake_hi_reg <= reg_wdata;
      end
    end
  end

  // Per-state supply registers; analogue enable bit is read-only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg[0] <= PMS_DORMANT_RESET;
      state_reg[1] <= PMS_RESUME1_RESET;
      state_reg[2] <= PMS_RESUME2_RESET;
      state_reg[3] <= PMS_ACTIVE_RESET;
      state_reg[4] <= PMS_SUSPEND1_RESET;
      state_reg[5] <= PMS_SUSPEND2_RESET;
    end else if (reg_wr) begin
      for (int i = 0; i < 6; i++) begin
        if (reg_addr == PMS_OFS_DORMANT + 8'(4 * i)) begin
          state_reg[i] <= (reg_wdata & (i == 3 ? PMS_ACTIVE_RW_MASK : PMS_ST_RW_MASK)
                           & ~(32'h1 << PMS_ST_ANA_EN))
                          | (state_reg[i] & (32'h1 << PMS_ST_ANA_EN));
        end
      end
    end
  end

  // Regulator control and level registers, plain storage
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_ctrl_reg <= PMS_LEVEL_RESET;
      core_level_reg <= PMS_LEVEL_RESET;
      pll_level_reg <= PMS_LEVEL_RESET;
    end else if (reg_wr) begin
      if (reg_addr == PMS_OFS_REG_CTRL) begin
        reg_ctrl_reg <= reg_wdata;
      end
      if (reg_addr == PMS_OFS_CORE_LEVEL) begin
        core_level_reg <= reg_wdata;
      end
      if (reg_addr == PMS_OFS_PLL_LEVEL) begin
        pll_level_reg <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path; re-apply bit reads zero as it is write-only, unmapped reads zero

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (reg_addr)
      PMS_OFS_GENERAL: rdata_next = gen_reg;
      PMS_OFS_WAKE_LO: rdata_next = wake_lo_reg;
      PMS_OFS_WAKE_HI: rdata_next = wake_hi_reg;
      PMS_OFS_DORMANT: rdata_next = state_reg[0];
      PMS_OFS_RESUME1: rdata_next = state_reg[1];
      PMS_OFS_RESUME2: rdata_next = state_reg[2];
      PMS_OFS_ACTIVE: rdata_next = state_reg[3];
      PMS_OFS_SUSPEND1: rdata_next = state_reg[4];
      PMS_OFS_SUSPEND2: rdata_next = state_reg[5];
      PMS_OFS_SEQ_STATUS: rdata_next = {29'h0, state_reg_q};
      PMS_OFS_REG_CTRL: rdata_next = reg_ctrl_reg;
      PMS_OFS_SUPPLY_STATUS: rdata_next = {28'h0, io_good, pll_good, ana_good, core_good};
      PMS_OFS_CORE_LEVEL: rdata_next = core_level_reg;
      PMS_OFS_PLL_LEVEL: rdata_next = pll_level_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Read data register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wake detection and dwell counting

  // Timer match reaches or passes; high word only joins in 64-bit mode
  always_comb begin
    wake_hit = 1'b0;
    if (gen_reg[PMS_GC_TIMER_WAKE]) begin
      if (gen_reg[PMS_GC_WIDE_TIMER]) begin
        wake_hit = rtc_count >= {wake_hi_reg, wake_lo_reg};
      end else begin
        wake_hit = rtc_count[31:0] >= wake_lo_reg;
      end
    end
    if (gen_reg[PMS_GC_PIN_WAKE] && wake_pin == gen_reg[PMS_GC_PIN_POL]) begin
      wake_hit = 1'b1;
    end
  end

  // Every enabled supply must report good
  always_comb begin
    supplies_good = (!cur_cfg[PMS_ST_CORE_EN] || core_good)
                    && (!cur_cfg[PMS_ST_ANA_EN] || ana_good)
                    && (!cur_cfg[PMS_ST_PLL_EN] || pll_good)
                    && (!cur_cfg[PMS_ST_IO_EN] || io_good);
  end

  // Asleep on the slow clock counts slow ticks, otherwise every system cycle
  assign count_tick = (state_reg_q == PMS_DORMANT && !gen_reg[PMS_GC_SLEEP_CLK])
                      ? slow_tick : 1'b1;
  assign cur_cfg = state_reg[state_reg_q];
  assign cur_log2 = cur_cfg[PMS_ST_DWELL_LSB +: 5];
  // Dwell of 2^n cycles is complete when the count reaches 2^n - 1 ticks
  assign dwell_done = (DWELL_W'({1'b0, dwell_reg}) + DWELL_W'(1)) >> cur_log2 != '0;

  // Dwell counter restarts on every state entry and holds once the dwell is done
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dwell_reg <= '0;
    end else if (state_next != state_reg_q) begin
      dwell_reg <= '0;
    end else if (count_tick && !dwell_done) begin
      dwell_reg <= dwell_reg + DWELL_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State machine

  always_comb begin
    state_next = state_reg_q;
    unique case (state_reg_q)
      PMS_DORMANT: if (dwell_done && count_tick && wake_hit) state_next = PMS_RESUME_PHASE_ONE;
      PMS_RESUME_PHASE_ONE: if (dwell_done && supplies_good) state_next = PMS_RESUME_PHASE_TWO;
      PMS_RESUME_PHASE_TWO: if (dwell_done && supplies_good) state_next = PMS_ACTIVE_STATE;
      PMS_ACTIVE_STATE: if (gen_reg[PMS_GC_SLEEP_GO]) state_next = PMS_SUSPEND_PHASE_ONE;
      PMS_SUSPEND_PHASE_ONE: if (dwell_done) state_next = PMS_SUSPEND_PHASE_TWO;
      PMS_SUSPEND_PHASE_TWO: if (dwell_done) state_next = PMS_DORMANT;
      default: state_next = PMS_DORMANT;
    endcase
  end

  // Reset lands in the active state so the device runs after power-on
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg_q <= PMS_ACTIVE_STATE;
    end else begin
      state_reg_q <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, loaded on state entry or re-apply so mid-state writes do not glitch rails

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      core_regulator_en <= PMS_ACTIVE_RESET[PMS_ST_CORE_EN];
      analogue_regulator_en <= PMS_ACTIVE_RESET[PMS_ST_ANA_EN];
      pll_supply_regulator_en <= PMS_ACTIVE_RESET[PMS_ST_PLL_EN];
      io_supply_output_en <= PMS_ACTIVE_RESET[PMS_ST_IO_EN];
      core_regulator_pfm <= 1'b0;
      analogue_regulator_pfm <= 1'b0;
      tile_clk_stop <= 1'b0;
    end else if (state_next != state_reg_q
                 || (reapply_reg && state_reg_q == PMS_ACTIVE_STATE)) begin
      core_regulator_en <= state_reg[state_next][PMS_ST_CORE_EN];
      analogue_regulator_en <= state_reg[state_next][PMS_ST_ANA_EN];
      pll_supply_regulator_en <= state_reg[state_next][PMS_ST_PLL_EN];
      io_supply_output_en <= state_reg[state_next][PMS_ST_IO_EN];
      core_regulator_pfm <= state_reg[state_next][PMS_ST_CORE_PFM];
      analogue_regulator_pfm <= state_reg[state_next][PMS_ST_ANA_PFM];
      tile_clk_stop <= state_reg[state_next][PMS_ST_CLK_STOP];
    end
  end

  // Mode outputs mirrored from general control; level and state outputs registered alongside
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_clk_default <= 1'b0;
      usb_pwr_up_en <= 1'b0;
      usb_pwr_down_en <= 1'b0;
      use_default_levels <= 1'b0;
      core_level <= PMS_LEVEL_RESET;
      pll_level <= PMS_LEVEL_RESET;
      seq_state <= 3'h3;
    end else begin
      sleep_clk_default <= gen_reg[PMS_GC_SLEEP_CLK];
      usb_pwr_up_en <= gen_reg[PMS_GC_USB_UP];
      usb_pwr_down_en <= gen_reg[PMS_GC_USB_DOWN];
      use_default_levels <= gen_reg[PMS_GC_DEFAULT_LEVELS];
      core_level <= core_level_reg;
      pll_level <= pll_level_reg;
      seq_state <= state_next;
    end
  end

endmodule : pms_power_mode_sequencer

// File: bench/pms_checker_props.sv
/*
  Port-level assertions for the power mode sequencer.
  Assumes it is bound to pms_power_mode_sequencer and sees its ports only.
*/
`timescale 1ns/1ns
module pms_checker (
  input wire logic sys_clk, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic [7:0] reg_addr, // Register offset
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic [31:0] reg_rdata, // Read data
  input wire logic core_good, // Core rail good
  input wire logic ana_good, // Analogue rail good
  input wire logic pll_good, // PLL rail good
  input wire logic io_good, // IO rail good
  input wire logic core_regulator_en, // Core enable
  input wire logic analogue_regulator_en, // Analogue enable
  input wire logic pll_supply_regulator_en, // PLL enable
  input wire logic io_supply_output_en, // IO enable
  input wire logic sleep_clk_default, // Sleep clock choice
  input wire logic usb_pwr_up_en, // USB up choice
  input wire logic usb_pwr_down_en, // USB down choice
  input wire logic use_default_levels, // Level choice
  input wire logic [2:0] seq_state // Sequencer state
);
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  logic sup_ok;
  ////////////////////////////////////////
  // A disabled rail never holds the sequence back
  assign sup_ok = (core_good | !core_regulator_en) & (ana_good | !analogue_regulator_en)
    & (pll_good | !pll_supply_regulator_en) & (io_good | !io_supply_output_en);
  a_sleep_start: assert property (
    reg_wr && reg_addr == 8'h00 && reg_wdata[1] && seq_state == 3'h3 |-> ##2 seq_state == 3'h4)
    else $error("sleep request did not reach suspend phase one");
  a_state_order: assert property (
    $changed(seq_state) |-> seq_state == (($past(seq_state) == 3'h5) ? 3'h0 : $past(seq_state) + 3'h1))
    else $error("state left its cyclic order");
  a_asleep_ana: assert property (seq_state == 3'h0 |-> !analogue_regulator_en)
    else $error("analogue regulator on while asleep");
  a_gen_copies: assert property (
    reg_wr && reg_addr == 8'h00 |-> ##2 {usb_pwr_up_en, usb_pwr_down_en, use_default_levels,
    sleep_clk_default} == {$past(reg_wdata[9:7], 2), $past(reg_wdata[0], 2)})
    else $error("general control outputs differ from written bits");
  a_resume_good: assert property (
    $changed(seq_state) && $past(seq_state) inside {3'h1, 3'h2} |-> $past(sup_ok))
    else $error("resume state left with an enabled rail not good");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h28 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_status_read: assert property (
    reg_rd && reg_addr == 8'h24 |=> reg_rdata == {29'h0, $past(seq_state)})
    else $error("status read does not give the state");
endmodule : pms_checker
bind pms_power_mode_sequencer pms_checker u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .core_good(core_good), .ana_good(ana_good), .pll_good(pll_good),
  .io_good(io_good), .core_regulator_en(core_regulator_en),
  .analogue_regulator_en(analogue_regulator_en), .pll_supply_regulator_en(pll_supply_regulator_en),
  .io_supply_output_en(io_supply_output_en), .sleep_clk_default(sleep_clk_default),
  .usb_pwr_up_en(usb_pwr_up_en), .usb_pwr_down_en(usb_pwr_down_en),
  .use_default_levels(use_default_levels), .seq_state(seq_state));

// File: bench/pms_supply_model.sv
/*
  Supply rail model: good flags follow the enables after a lag.
  Assumes enables arrive as {io,pll,ana,core}; the bench sets the lag.
*/
`timescale 1ns/1ns
module pms_supply_model (
  input wire logic sys_clk, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic [3:0] rail_en, // Enables {io,pll,ana,core}
  input wire logic [7:0] rail_lag, // Cycles a new rail takes to come good
  output logic [3:0] rail_good // Good flags, same order
);
  logic [3:0] en_reg;
  logic [7:0] lag_cnt;
  ////////////////////////////////////////
  // A newly enabled rail restarts the lag; a disabled rail is never good
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_reg <= 4'h0;
      lag_cnt <= 8'h00;
      rail_good <= 4'h0;
    end else begin
      en_reg <= rail_en;
      lag_cnt <= ((rail_en & ~en_reg) != 4'h0) ? 8'h00 : lag_cnt + {7'h00, lag_cnt != 8'hFF};
      rail_good <= rail_en & en_reg & (rail_good | {4{lag_cnt >= rail_lag}});
    end
  end
endmodule : pms_supply_model

// File: bench/tb_top.sv
/*
  Self-checking bench for the power mode sequencer.
  Assumes the supply model as far side; bench drives registers, clocks and wake pin.
*/
`timescale 1ns/1ns
module tb_top
  import pms_pkg::*;
;
  logic sys_clk, arst_n, reg_wr, reg_rd, wake_pin;
  // Free-running stimulus starts valued, so the time-zero clock fall cannot race it
  logic slow_tick = 1'b0;
  logic [7:0] tick_div = 8'h00;
  logic [63:0] rtc_count = 64'h1_0000_0000;
  logic core_pfm, ana_pfm, tile_stop, slp_clk, usb_up, usb_dn, dflt_lv;
  logic [7:0] reg_addr, rail_lag;
  logic [31:0] reg_wdata, reg_rdata, core_level, pll_level;
  logic [3:0] rail_en, rail_good;
  logic [2:0] seq_state;
  int errors, n_tests;
  pms_power_mode_sequencer dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rtc_count(rtc_count), .wake_pin(wake_pin), .slow_tick(slow_tick),
    .core_good(rail_good[0]), .ana_good(rail_good[1]), .pll_good(rail_good[2]),
    .io_good(rail_good[3]), .core_regulator_en(rail_en[0]), .analogue_regulator_en(rail_en[1]),
    .pll_supply_regulator_en(rail_en[2]), .io_supply_output_en(rail_en[3]),
    .core_regulator_pfm(core_pfm), .analogue_regulator_pfm(ana_pfm), .tile_clk_stop(tile_stop),
    .sleep_clk_default(slp_clk), .usb_pwr_up_en(usb_up), .usb_pwr_down_en(usb_dn),
    .use_default_levels(dflt_lv), .core_level(core_level), .pll_level(pll_level),
    .seq_state(seq_state));
  pms_supply_model u_sup (.sys_clk(sys_clk), .arst_n(arst_n), .rail_en(rail_en),
    .rail_lag(rail_lag), .rail_good(rail_good));
  ////////////////////////////////////////
  // Clock source
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Real-time counter and a slow tick every 16 cycles, driven off the sampling edge
  always @(negedge sys_clk) begin
    rtc_count <= rtc_count + 64'h1;
    tick_div <= tick_div + 8'h1;
    slow_tick <= (tick_div[3:0] == 4'hF);
  end
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask : wr
  // Read strobe for one cycle; data is taken once the registered answer has landed
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    @(negedge sys_clk);
    chk("reg read", reg_rdata, exp);
  endtask : rdc
  task automatic wait_state(input logic [2:0] s, input int lim);
    for (int i = 0; i < lim && seq_state !== s; i++) @(negedge sys_clk);
    chk("seq_state", seq_state, s);
  endtask : wait_state
  task automatic t_reset();
    logic [7:0] adr [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28};
    logic [31:0] val [11] = '{PMS_GC_RESET, 32'h0, 32'h0, PMS_DORMANT_RESET, PMS_RESUME1_RESET,
      PMS_RESUME2_RESET, PMS_ACTIVE_RESET, PMS_SUSPEND1_RESET, PMS_SUSPEND2_RESET, 32'h3, 32'h0};
    chk("reset outputs", {seq_state, rail_en, core_pfm}, {3'h3, 4'hF, 1'b0});
    for (int i = 0; i < 11; i++) rdc(adr[i], val[i]);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_access();
    wr(8'h0C, 32'hFFFF_FFFF);
    rdc(8'h0C, PMS_ST_RW_MASK);
    wr(8'h00, 32'hFFFF_FFFD);
    rdc(8'h00, PMS_GC_RW_MASK & 32'hFFFF_FFFD);
    chk("gen outputs", {usb_up, usb_dn, dflt_lv, slp_clk}, 4'hF);
    wr(8'h28, 32'hFFFF_FFFF);
    rdc(8'h28, 32'h0);
    wr(8'h34, 32'h1234_5678);
    rdc(8'h34, 32'h1234_5678);
    chk("core level", core_level, 32'h1234_5678);
    wr(8'h40, 32'h8765_4321);
    rdc(8'h40, 32'h8765_4321);
    chk("pll level", pll_level, 32'h8765_4321);
    wr(8'h00, PMS_GC_RESET);
    $display("t_access done");
  endtask : t_access
  // Pin wake through the full cycle; the pin sits at its idle level for 40 asleep cycles, then goes to its active level
  task automatic t_pin(input logic pol, input logic [7:0] lag);
    rail_lag = lag;
    wake_pin = ~pol;
    wr(8'h0C, 32'h0002_4000);
    wr(8'h10, 32'h0002_0020);
    wr(8'h14, 32'h0002_0331);
    wr(8'h1C, 32'h0002_0033);
    wr(8'h20, 32'h0002_0020);
    wr(8'h00, {28'h0, pol, 3'h7});
    wait_state(3'h0, 40);
    chk("asleep outputs", {tile_stop, rail_en, slp_clk}, {1'b1, 4'h0, 1'b1});
    repeat (40) @(negedge sys_clk);
    chk("no wake", seq_state, 3'h0);
    wake_pin = pol;
    wait_state(3'h1, 20);
    chk("resume one rails", rail_en, 4'h8);
    wait_state(3'h2, 60);
    chk("pfm", {ana_pfm, core_pfm, rail_en[1]}, 3'h7);
    wait_state(3'h3, 60);
    rdc(8'h00, {28'h0, pol, 3'h5});
    $display("t_pin done");
  endtask : t_pin
  task automatic t_timer();
    int n;
    n = 0;
    wr(8'h0C, 32'h0003_0000);
    wr(8'h08, 32'hFFFF_FFFF);
    wr(8'h04, rtc_count[31:0] + 32'd40);
    wr(8'h00, 32'h0000_0012);
    wait_state(3'h0, 40);
    for (int i = 0; i < 400 && seq_state === 3'h0; i++) begin
      n++;
      @(negedge sys_clk);
    end
    chk("slow dwell", {n >= 112, n <= 150}, 2'b11);
    wait_state(3'h3, 60);
    wr(8'h08, rtc_count[63:32] + 32'h1);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h0000_0032);
    repeat (300) @(negedge sys_clk);
    chk("wide compare", seq_state, 3'h0);
    wr(8'h08, rtc_count[63:32]);
    wait_state(3'h3, 80);
    $display("t_timer done");
  endtask : t_timer
  task automatic t_reapply();
    wr(8'h18, 32'h0000_0330);
    repeat (3) @(negedge sys_clk);
    chk("not yet applied", {core_pfm, rail_en[0]}, 2'b01);
    wr(8'h00, 32'h0000_0048);
    repeat (3) @(negedge sys_clk);
    chk("re-applied", {core_pfm, rail_en[0]}, 2'b10);
    rdc(8'h00, PMS_GC_RESET);
    rdc(8'h18, 32'h0000_0332);
    $display("t_reapply done");
  endtask : t_reapply
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  // Cut a hang short well beyond the expected run length
  initial begin
    #200000;
    errors++;
    complete_run();
  end
  initial begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    wake_pin = 1'b0;
    rail_lag = 8'd4;
    // Count rising edges: the clock's first fall at time zero is not a cycle
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    t_reset();
    t_access();
    t_pin(1'b1, 8'd20);
    t_pin(1'b0, 8'd0);
    t_timer();
    t_reapply();
    complete_run();
  end
endmodule : tb_top
